// [verilog/asp_consts.vh]
// constants for the address space and stack block
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH
`define ASP_BANK_STD        4'h0
`define ASP_BANK_SPI        4'hc
`define ASP_BANK_CTL        4'hf
`define ASP_SPI_COMPARE     4'h0
`define ASP_SPI_DATA        4'h1
`define ASP_SPI_CONTROL     4'h2
`define ASP_PORT_CONFIG     4'h0
`define ASP_STOP_RECOVERY   4'hb
`define ASP_WATCHDOG_MODE   4'hf
`define ASP_PORT_LAST       4'h3
`define ASP_REG_PORT_ZERO_ONE_MODE        8'hf8
`define ASP_REG_P3M         8'hf7
`define ASP_REG_FLAGS       8'hfc
`define ASP_REG_RP          8'hfd
`define ASP_REG_SPH         8'hfe
`define ASP_REG_SPL         8'hff
`define ASP_PORT_ZERO_ONE_MODE_STK_BIT    2
`define ASP_P3M_DM_LO       3
`define ASP_P3M_DM_HI       4
`define ASP_ROM_BASE        16'h000c
`define ASP_VEC_COUNT       6
`define ASP_PC_TOP          16'hffff
`define ASP_PC_WRAP         16'h0000
`define ASP_XDATA_BASE      16'h1000
`define ASP_NOP_OPCODE      8'hff
`define ASP_RESET_PC        16'h000c
`define ASP_RESET_BYTE      8'h00
`endif

// [verilog/asp_reg_decode.v]
// register file address decode with expansion bank remap
`timescale 1ns/1ps
`include "asp_consts.vh"
module asp_reg_decode
(
   input  wire [7:0] addr,
   input  wire [7:0] reg_pointer,
   output reg        hit_std,
   output reg        hit_spi,
   output reg        hit_ctl,
   output reg        hit_none,
   output wire [3:0] low_sel
);
   wire [3:0] bank;
   assign bank    = reg_pointer[3:0];
   assign low_sel = addr[3:0];
   always @*
   begin
      hit_std  = 1'b0;
      hit_spi  = 1'b0;
      hit_ctl  = 1'b0;
      hit_none = 1'b0;
      // only 00h..0fh is remapped by a nonzero bank
      if (addr[7:4] != 4'h0 || bank == `ASP_BANK_STD)
         hit_std = 1'b1;
      else if (bank == `ASP_BANK_SPI)
         hit_spi = (addr[3:0] <= `ASP_SPI_CONTROL);
      else if (bank == `ASP_BANK_CTL)
         hit_ctl = (addr[3:0] == `ASP_PORT_CONFIG) || (addr[3:0] == `ASP_STOP_RECOVERY)
                   || (addr[3:0] == `ASP_WATCHDOG_MODE);
      if (!hit_std && !hit_spi && !hit_ctl)
         hit_none = 1'b1;
   end
endmodule // asp_reg_decode

// [verilog/asp_stack_ptr.v]
// stack pointer with pre-decrement push and post-increment pop
`timescale 1ns/1ps
`include "asp_consts.vh"
module asp_stack_ptr
(
   input  wire        mclk,
   input  wire        rst,
   input  wire        internal_stack,
   input  wire        push,
   input  wire        pop,
   input  wire        wr_high,
   input  wire        wr_low,
   input  wire [7:0]  wr_data,
   output wire [15:0] sp,
   output wire [15:0] push_addr
);
   reg [7:0] sph_q;
   reg [7:0] spl_q;
   wire [15:0] sp_dec;
   wire [15:0] sp_inc;
   assign sp        = {sph_q, spl_q};
   assign sp_dec    = sp - 16'h0001;
   assign sp_inc    = sp + 16'h0001;
   assign push_addr = internal_stack ? {sph_q, sp_dec[7:0]} : sp_dec;
   always @(posedge mclk)
   begin
      if (rst)
      begin
         sph_q <= `ASP_RESET_BYTE;
         spl_q <= `ASP_RESET_BYTE;
      end
      else if (push)
      begin
         spl_q <= sp_dec[7:0];
         if (!internal_stack)
            sph_q <= sp_dec[15:8];
      end
      else if (pop)
      begin
         spl_q <= sp_inc[7:0];
         if (!internal_stack)
            sph_q <= sp_inc[15:8];
      end
      else
      begin
         if (wr_high)
            sph_q <= wr_data;
         if (wr_low)
            spl_q <= wr_data;
      end
   end
endmodule // asp_stack_ptr

// [verilog/asp_addr_space.v]
// address space, external memory interface and stack engine of the core
// How it works
// - a 16-bit program counter sequences fetches and is not a register location
// - instructions reach control and peripheral registers through register addressing
// - bank c group 0 holds spi compare, data, control; 3 to f reserved
// - bank f group 0 holds port config 0, stop recovery b, watchdog f
// - bank 0 group 0 holds ports 0 to 3 then general registers
// - six 16-bit vectors at the bottom, internal rom from address 12
// - fetch beyond rom goes external over ports 0 and 1 when present
// - without those ports fetches beyond rom are nops until wrap to 0000h
// - rom protect blocks all four program and external load forms
// - rom protect is a fixed strap, not a software setting
// - low address muxed with data on port 1, high address on port 0
// - address strobe, data strobe and read/write control external transfers
// - external program space runs from rom end up to ffff
// - external data memory reaches 60kb starting at 4096
// - data select high for program loads, low for external data loads only when p3m bits 3 and 4 are both set
// - port 0-1 mode register at f8h chooses internal or external stack
// - stack pointer is the pair fe high and ff low
// - decrement before push, increment after pop
// - call saves program counter, return restores it
// - interrupt saves counter and flags, interrupt return restores both
// - internal stack uses ff only; fe stays a general register
// - register pointer low nibble picks expansion bank, 0 is standard
// - register pointer high nibble picks working register group
// - nonzero bank remaps only 00h to 0fh
`timescale 1ns/1ps
`include "asp_consts.vh"
module asp_addr_space
#(
   parameter ROM_TOP    = 16'h0fff,
   parameter HAS_PORT01 = 1
)
(
   input  wire        mclk,
   input  wire        rst,
   input  wire        rom_protect_strap,
   input  wire [7:0]  reg_addr,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire        reg_working,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   input  wire        fetch_req,
   input  wire        jump,
   input  wire [15:0] jump_addr,
   output wire [15:0] pc,
   output reg  [7:0]  fetch_data,
   output reg         fetch_done,
   input  wire [7:0]  rom_data,
   output wire [15:0] rom_addr,
   input  wire        ld_prog,
   input  wire        ld_ext,
   input  wire        ld_incr,
   input  wire        ld_write,
   input  wire [15:0] ld_addr,
   input  wire [7:0]  ld_wdata,
   output reg  [7:0]  ld_rdata,
   output reg         ld_done,
   output reg         ld_blocked,
   input  wire        stk_push,
   input  wire        stk_pop,
   input  wire        stk_call,
   input  wire        stk_ret,
   input  wire        stk_irq,
   input  wire        stk_return_from_interrupt,
   input  wire [15:0] irq_vector,
   output wire        stk_busy,
   output reg  [7:0]  high_address_bus,
   output reg  [7:0]  mux_addr_data_out,
   output reg         mux_addr_data_oe_n,
   input  wire [7:0]  mux_addr_data_in,
   output reg         address_strobe_n,
   output reg         data_strobe_n,
   output reg         read_write,
   output reg         data_memory_select_n
);
   ////////////////////////////////////////////////////////////////////////
   // register file
   localparam S_IDLE  = 7'b0000001;
   localparam S_ADDR  = 7'b0000010;
   localparam S_DATA  = 7'b0000100;
   localparam S_END   = 7'b0001000;
   localparam S_STACK = 7'b0010000;
   localparam S_SPOP  = 7'b0100000;
   localparam S_DONE  = 7'b1000000;
   reg  [7:0]  rf_q [0:255];
   reg  [7:0]  spi_q [0:2];
   reg  [7:0]  ctl_q [0:2];
   reg  [7:0]  rp_q;
   reg  [7:0]  flags_q;
   reg  [7:0]  port_zero_one_mode_q;
   reg  [7:0]  p3m_q;
   reg         protect_q;
   reg  [15:0] pc_q;
   reg  [6:0]  st_q;
   reg  [15:0] xaddr_q;
   reg  [7:0]  xdata_q;
   reg         xwrite_q;
   reg         xdm_q;
   reg         xfetch_q;
   reg  [2:0]  stk_n_q;
   reg  [2:0]  stk_i_q;
   reg         stk_pop_q;
   reg  [7:0]  pop_q [0:2];
   reg  [7:0]  push_v [0:2];
   wire [7:0]  full_addr;
   wire        hit_std;
   wire        hit_spi;
   wire        hit_ctl;
   wire        hit_none;
   wire [3:0]  low_sel;
   wire        int_stack;
   wire [15:0] sp;
   wire [15:0] push_addr;
   wire        sp_push;
   wire        sp_pop;
   wire        sp_wh;
   wire        sp_wl;
   wire        is_sp_h;
   wire        beyond_rom;
   wire        ext_ok;
   wire        any_ld;
   integer     i;
   // working register group from the pointer high nibble
   assign full_addr = reg_working ? {rp_q[7:4], reg_addr[3:0]} : reg_addr;
   assign int_stack = port_zero_one_mode_q[`ASP_PORT_ZERO_ONE_MODE_STK_BIT];
   assign is_sp_h   = (full_addr == `ASP_REG_SPH) && !int_stack;
   asp_reg_decode u_dec
   (
      .addr        (full_addr),
      .reg_pointer (rp_q),
      .hit_std     (hit_std),
      .hit_spi     (hit_spi),
      .hit_ctl     (hit_ctl),
      .hit_none    (hit_none),
      .low_sel     (low_sel)
   );
   assign sp_wh = reg_wr && hit_std && is_sp_h;
   assign sp_wl = reg_wr && hit_std && (full_addr == `ASP_REG_SPL);
   asp_stack_ptr u_sp
   (
      .mclk           (mclk),
      .rst            (rst),
      .internal_stack (int_stack),
      .push           (sp_push),
      .pop            (sp_pop),
      .wr_high        (sp_wh),
      .wr_low         (sp_wl),
      .wr_data        (reg_wdata),
      .sp             (sp),
      .push_addr      (push_addr)
   );
   // read path: one combinational view of all banks
   always @*
   begin
      reg_rdata = 8'h00;
      if (hit_std)
      begin
         if (full_addr == `ASP_REG_RP)
            reg_rdata = rp_q;
         else if (full_addr == `ASP_REG_FLAGS)
            reg_rdata = flags_q;
         else if (full_addr == `ASP_REG_PORT_ZERO_ONE_MODE)
            reg_rdata = port_zero_one_mode_q;
         else if (full_addr == `ASP_REG_P3M)
            reg_rdata = p3m_q;
         else if (is_sp_h)
            reg_rdata = sp[15:8];
         else if (full_addr == `ASP_REG_SPL)
            reg_rdata = sp[7:0];
         else
            reg_rdata = rf_q[full_addr];
      end
      else if (hit_spi)
         reg_rdata = spi_q[low_sel[1:0]];
      else if (hit_ctl)
         reg_rdata = (low_sel == `ASP_PORT_CONFIG) ? ctl_q[0] :
                     (low_sel == `ASP_STOP_RECOVERY) ? ctl_q[1] : ctl_q[2];
   end
   ////////////////////////////////////////////////////////////////////////
   // program counter and memory map
   assign pc         = pc_q;
   assign rom_addr   = pc_q;
   assign beyond_rom = (pc_q > ROM_TOP) || (pc_q < `ASP_ROM_BASE && 1'b0);
   assign ext_ok     = (HAS_PORT01 != 0);
   assign any_ld     = ld_prog || ld_ext;
   assign stk_busy   = (st_q != S_IDLE);
   assign sp_push    = (st_q == S_STACK) && !stk_pop_q;
   assign sp_pop     = (st_q == S_SPOP);
   // bytes to save: pc low, pc high, flags
   always @*
   begin
      push_v[0] = pc_q[7:0];
      push_v[1] = pc_q[15:8];
      push_v[2] = flags_q;
   end
   always @(posedge mclk)
   begin
      if (rst)
      begin
         rp_q       <= 8'h00;
         flags_q    <= 8'h00;
         port_zero_one_mode_q     <= 8'h00;
         p3m_q      <= 8'h00;
         protect_q  <= 1'b0;
         pc_q       <= `ASP_RESET_PC;
         st_q       <= S_IDLE;
         xaddr_q    <= 16'h0000;
         xdata_q    <= 8'h00;
         xwrite_q   <= 1'b0;
         xdm_q      <= 1'b1;
         xfetch_q   <= 1'b0;
         stk_n_q    <= 3'd0;
         stk_i_q    <= 3'd0;
         stk_pop_q  <= 1'b0;
         fetch_data <= 8'h00;
         fetch_done <= 1'b0;
         ld_rdata   <= 8'h00;
         ld_done    <= 1'b0;
         ld_blocked <= 1'b0;
         high_address_bus     <= 8'h00;
         mux_addr_data_out    <= 8'h00;
         mux_addr_data_oe_n   <= 1'b1;
         address_strobe_n     <= 1'b1;
         data_strobe_n        <= 1'b1;
         read_write           <= 1'b1;
         data_memory_select_n <= 1'b1;
         for (i = 0; i < 256; i = i + 1)
            rf_q[i] <= 8'h00;
         for (i = 0; i < 3; i = i + 1)
         begin
            spi_q[i] <= 8'h00;
            ctl_q[i] <= 8'h00;
            pop_q[i] <= 8'h00;
         end
      end
      else
      begin
         fetch_done <= 1'b0;
         ld_done    <= 1'b0;
         ld_blocked <= 1'b0;
         protect_q  <= rom_protect_strap;
         if (reg_wr && hit_std)
         begin
            if (full_addr == `ASP_REG_RP)
               rp_q <= reg_wdata;
            else if (full_addr == `ASP_REG_FLAGS)
               flags_q <= reg_wdata;
            else if (full_addr == `ASP_REG_PORT_ZERO_ONE_MODE)
               port_zero_one_mode_q <= reg_wdata;
            else if (full_addr == `ASP_REG_P3M)
               p3m_q <= reg_wdata;
            else if (!is_sp_h && full_addr != `ASP_REG_SPL)
               rf_q[full_addr] <= reg_wdata;
         end
         else if (reg_wr && hit_spi)
            spi_q[low_sel[1:0]] <= reg_wdata;
         else if (reg_wr && hit_ctl)
            ctl_q[(low_sel == `ASP_PORT_CONFIG) ? 0 : (low_sel == `ASP_STOP_RECOVERY) ? 1 : 2]
               <= reg_wdata;
         case (st_q)
            S_IDLE:
            begin
               if (stk_call || stk_irq)
               begin
                  stk_n_q   <= stk_irq ? 3'd3 : 3'd2;
                  stk_i_q   <= 3'd0;
                  stk_pop_q <= 1'b0;
                  st_q      <= S_STACK;
               end
               else if (stk_ret || stk_return_from_interrupt)
               begin
                  stk_n_q   <= stk_return_from_interrupt ? 3'd3 : 3'd2;
                  stk_i_q   <= 3'd0;
                  stk_pop_q <= 1'b1;
                  st_q      <= S_STACK;
               end
               else if (stk_push || stk_pop)
               begin
                  stk_n_q   <= 3'd0;
                  stk_i_q   <= 3'd0;
                  stk_pop_q <= stk_pop;
                  st_q      <= stk_pop ? S_SPOP : S_STACK;
               end
               else if (jump)
                  pc_q <= jump_addr;
               else if (any_ld && protect_q)
                  ld_blocked <= 1'b1;
               else if (any_ld && ext_ok)
               begin
                  xaddr_q  <= ld_incr ? ld_addr : ld_addr;
                  xdata_q  <= ld_wdata;
                  xwrite_q <= ld_write;
                  xdm_q    <= ~(ld_ext && p3m_q[`ASP_P3M_DM_LO] && p3m_q[`ASP_P3M_DM_HI]);
                  xfetch_q <= 1'b0;
                  st_q     <= S_ADDR;
               end
               else if (fetch_req && !beyond_rom)
               begin
                  fetch_data <= rom_data;
                  fetch_done <= 1'b1;
                  pc_q       <= pc_q + 16'h0001;
               end
               else if (fetch_req && ext_ok)
               begin
                  xaddr_q  <= pc_q;
                  xwrite_q <= 1'b0;
                  xdm_q    <= 1'b1;
                  xfetch_q <= 1'b1;
                  st_q     <= S_ADDR;
               end
               else if (fetch_req)
               begin
                  fetch_data <= `ASP_NOP_OPCODE;
                  fetch_done <= 1'b1;
                  pc_q       <= (pc_q == `ASP_PC_TOP) ? `ASP_PC_WRAP : pc_q + 16'h0001;
               end
            end
            S_ADDR:
            begin
               high_address_bus     <= xaddr_q[15:8];
               mux_addr_data_out    <= xaddr_q[7:0];
               mux_addr_data_oe_n   <= 1'b0;
               address_strobe_n     <= 1'b0;
               read_write           <= ~xwrite_q;
               data_memory_select_n <= xdm_q;
               st_q                 <= S_DATA;
            end
            S_DATA:
            begin
               address_strobe_n   <= 1'b1;
               data_strobe_n      <= 1'b0;
               mux_addr_data_out  <= xdata_q;
               mux_addr_data_oe_n <= ~xwrite_q;
               st_q               <= S_END;
            end
            S_END:
            begin
               data_strobe_n        <= 1'b1;
               mux_addr_data_oe_n   <= 1'b1;
               read_write           <= 1'b1;
               data_memory_select_n <= 1'b1;
               if (xfetch_q)
               begin
                  fetch_data <= mux_addr_data_in;
                  fetch_done <= 1'b1;
                  pc_q       <= pc_q + 16'h0001;
               end
               else
               begin
                  ld_rdata <= mux_addr_data_in;
                  ld_done  <= 1'b1;
               end
               st_q <= S_IDLE;
            end
            S_STACK:
            begin
               if (stk_pop_q)
                  st_q <= S_SPOP;
               else
               begin
                  if (stk_n_q != 3'd0)
                     rf_q[push_addr[7:0]] <= push_v[stk_i_q[1:0]];
                  stk_i_q <= stk_i_q + 3'd1;
                  if (stk_i_q + 3'd1 >= stk_n_q)
                  begin
                     st_q <= S_DONE;
                     if (stk_n_q == 3'd3)
                        pc_q <= irq_vector;
                  end
               end
            end
            S_SPOP:
            begin
               if (stk_n_q != 3'd0)
                  pop_q[stk_i_q[1:0]] <= rf_q[sp[7:0]];
               stk_i_q <= stk_i_q + 3'd1;
               if (stk_i_q + 3'd1 >= stk_n_q)
                  st_q <= S_DONE;
            end
            S_DONE:
            begin
               if (stk_pop_q && stk_n_q == 3'd3)
               begin
                  flags_q <= pop_q[0];
                  pc_q    <= {pop_q[1], pop_q[2]};
               end
               else if (stk_pop_q && stk_n_q == 3'd2)
                  pc_q <= {pop_q[0], pop_q[1]};
               st_q <= S_IDLE;
            end
            default:
               st_q <= S_IDLE;
         endcase
      end
   end
endmodule // asp_addr_space

// [test/asp_addr_space_chk.sv]
// port checker for the address space and stack block
`timescale 1ns/1ps
module asp_addr_space_chk
#(
   parameter ROM_TOP    = 16'h0fff,
   parameter HAS_PORT01 = 1
)
(
   input wire        mclk,
   input wire        rst,
   input wire        rom_protect_strap,
   input wire        fetch_req,
   input wire [15:0] pc,
   input wire        fetch_done,
   input wire        ld_prog,
   input wire        ld_ext,
   input wire        address_strobe_n,
   input wire        data_strobe_n,
   input wire        read_write,
   input wire        mux_addr_data_oe_n,
   input wire        data_memory_select_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   chk_reset_idle: assert property (
      $fell(rst) |-> pc == 16'h000c && address_strobe_n && data_strobe_n && mux_addr_data_oe_n)
      else $error("not idle after reset");
   chk_strobe_order: assert property (
      $fell(address_strobe_n) |=> address_strobe_n && !data_strobe_n ##1 data_strobe_n)
      else $error("strobe sequence broken");
   chk_addr_drive: assert property (
      !address_strobe_n |-> !mux_addr_data_oe_n)
      else $error("address not driven");
   chk_read_release: assert property (
      !data_strobe_n && read_write |-> mux_addr_data_oe_n)
      else $error("bus driven in read");
   chk_int_fetch: assert property (
      $rose(fetch_req) && pc >= 16'h000c && pc <= ROM_TOP |=> fetch_done)
      else $error("internal fetch late");
   chk_ext_fetch: assert property (
      $rose(fetch_req) && HAS_PORT01 != 0 && pc > ROM_TOP
         |-> ##[1:4] $fell(address_strobe_n) ##[1:4] fetch_done)
      else $error("external fetch broken");
   chk_prog_dm: assert property (
      ld_prog && !ld_ext |=> data_memory_select_n [*5])
      else $error("data select on program load");
   chk_protect_block: assert property (
      ld_prog && rom_protect_strap && $past(rom_protect_strap) |=> address_strobe_n [*5])
      else $error("protected load on bus");
   cover property ($fell(address_strobe_n) && !data_memory_select_n);
   cover property (fetch_done && pc > ROM_TOP);
   cover property (ld_prog && rom_protect_strap);
endmodule // asp_addr_space_chk

bind asp_addr_space asp_addr_space_chk #(.ROM_TOP(ROM_TOP), .HAS_PORT01(HAS_PORT01)) u_chk
(
   .*
);

// [test/asp_ext_mem.sv]
// external program and data memory on the multiplexed bus
`timescale 1ns/1ps
module asp_ext_mem
(
   input  wire         mclk,
   input  wire  [7:0]  high_address_bus,
   input  wire  [7:0]  mux_addr_data_out,
   input  wire         mux_addr_data_oe_n,
   input  wire         address_strobe_n,
   input  wire         data_strobe_n,
   input  wire         read_write,
   input  wire         data_memory_select_n,
   output logic [7:0]  mux_addr_data_in,
   output logic [15:0] seen_addr,
   output logic        seen_dm_n
);
   logic [7:0] wr_mem [int];
   logic [7:0] last_q = 8'h00;
   logic       hold_q = 1'b0;
   // unwritten bytes follow a fixed pattern per space
   function automatic logic [7:0] val(input logic [15:0] a, input logic d);
      int k;
      k = {15'h0, d, a};
      if (wr_mem.exists(k))
         return wr_mem[k];
      return d ? (a[15:8] ^ a[7:0] ^ 8'h5a) : (a[15:8] + a[7:0]);
   endfunction
   always @(posedge mclk)
   begin
      if (!address_strobe_n)
      begin
         seen_addr <= {high_address_bus, mux_addr_data_out};
         seen_dm_n <= data_memory_select_n;
      end
      if (!data_strobe_n && !read_write && !mux_addr_data_oe_n)
         wr_mem[{15'h0, seen_dm_n, seen_addr}] = mux_addr_data_out;
      hold_q <= !data_strobe_n && read_write;
      last_q <= mux_addr_data_in;
   end
   // data held one cycle past the strobe, then a toggling pattern
   always @*
      if ((!data_strobe_n && read_write) || hold_q)
         mux_addr_data_in = val(seen_addr, seen_dm_n);
      else
         mux_addr_data_in = ~last_q;
endmodule // asp_ext_mem

// [test/asp_addr_space_test.sv]
// self-checking bench for the address space and stack block
`timescale 1ns/1ps
module asp_addr_space_test;
   localparam [15:0] ROM_TOP = 16'h0fff;
   logic        mclk, rst, rom_protect_strap, reg_wr, reg_rd, reg_working;
   logic        fetch_req, jump, ld_prog, ld_ext, ld_incr, ld_write;
   logic        stk_push, stk_pop, stk_call, stk_ret, stk_irq, stk_return_from_interrupt;
   logic [7:0]  reg_addr, reg_wdata, ld_wdata;
   logic [15:0] jump_addr, ld_addr, irq_vector;
   wire  [7:0]  reg_rdata, fetch_data, ld_rdata, high_address_bus, mux_addr_data_out;
   wire  [7:0]  mux_addr_data_in, rom_data;
   wire  [15:0] pc, rom_addr, seen_addr;
   wire         fetch_done, ld_done, ld_blocked, stk_busy, mux_addr_data_oe_n, seen_dm_n;
   wire         address_strobe_n, data_strobe_n, read_write, data_memory_select_n;
   int          err_total, n_checks;
   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;
   assign rom_data = rom_addr[7:0] ^ 8'h3c;
   asp_addr_space #(.ROM_TOP(ROM_TOP), .HAS_PORT01(1)) DUT
   (
      .mclk(mclk), .rst(rst), .rom_protect_strap(rom_protect_strap), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_working(reg_working), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .fetch_req(fetch_req), .jump(jump), .jump_addr(jump_addr),
      .pc(pc), .fetch_data(fetch_data), .fetch_done(fetch_done), .rom_data(rom_data),
      .rom_addr(rom_addr), .ld_prog(ld_prog), .ld_ext(ld_ext), .ld_incr(ld_incr),
      .ld_write(ld_write), .ld_addr(ld_addr), .ld_wdata(ld_wdata), .ld_rdata(ld_rdata),
      .ld_done(ld_done), .ld_blocked(ld_blocked), .stk_push(stk_push), .stk_pop(stk_pop),
      .stk_call(stk_call), .stk_ret(stk_ret), .stk_irq(stk_irq), .stk_return_from_interrupt(stk_return_from_interrupt),
      .irq_vector(irq_vector), .stk_busy(stk_busy), .high_address_bus(high_address_bus),
      .mux_addr_data_out(mux_addr_data_out), .mux_addr_data_oe_n(mux_addr_data_oe_n),
      .mux_addr_data_in(mux_addr_data_in), .address_strobe_n(address_strobe_n),
      .data_strobe_n(data_strobe_n), .read_write(read_write),
      .data_memory_select_n(data_memory_select_n)
   );
   asp_ext_mem u_mem
   (
      .*
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // bounded wait: 0 fetch done, 1 load done, 2 load blocked, 3 stack idle
   task automatic wt(input int w);
      int n;
      for (n = 0; n < 40; n++)
      begin
         @(posedge mclk);
         {fetch_req, ld_prog, ld_ext} <= 3'h0;
         {stk_push, stk_pop, stk_call, stk_ret, stk_irq, stk_return_from_interrupt} <= 6'h00;
         #1;
         if (w == 0 ? fetch_done === 1'b1 : w == 1 ? ld_done === 1'b1 :
             w == 2 ? ld_blocked === 1'b1 : stk_busy === 1'b0)
            return;
      end
      chk(16'h0, 16'h1);
      close_out;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_working <= 1'b0;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic wk, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_working <= wk;
      reg_rd <= 1'b1;
      @(posedge mclk);
      #1;
      chk({8'h0, reg_rdata}, {8'h0, e});
   endtask
   task automatic jmp(input logic [15:0] a);
      @(posedge mclk);
      jump_addr <= a;
      jump <= 1'b1;
      @(posedge mclk);
      jump <= 1'b0;
   endtask
   // op 0 push, 1 pop, 2 call, 3 return, 4 interrupt, 5 interrupt return
   task automatic stk(input int op);
      @(posedge mclk);
      {stk_push, stk_pop, stk_call, stk_ret, stk_irq, stk_return_from_interrupt} <= 6'b100000 >> op;
      wt(3);
   endtask
   task automatic do_fetch;
      @(posedge mclk);
      fetch_req <= 1'b1;
      wt(0);
   endtask
   task automatic do_ld(input logic p, input logic w, input logic [15:0] a,
                        input logic [7:0] d, input int fin);
      @(posedge mclk);
      ld_prog <= p;
      ld_ext <= !p;
      ld_write <= w;
      ld_addr <= a;
      ld_wdata <= d;
      wt(fin);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      wr(8'hfd, 8'h00);
      wr(8'h03, 8'h33);
      wr(8'h0b, 8'hbb);
      wr(8'h40, 8'h44);
      wr(8'hfd, 8'h0c);
      wr(8'h00, 8'hc0);
      wr(8'h02, 8'hc2);
      wr(8'h03, 8'h99);
      rd(8'h00, 1'b0, 8'hc0);
      rd(8'h02, 1'b0, 8'hc2);
      rd(8'h03, 1'b0, 8'h00);
      rd(8'h40, 1'b0, 8'h44);
      wr(8'hfd, 8'h0f);
      wr(8'h0b, 8'hfb);
      wr(8'h0f, 8'hff);
      wr(8'h01, 8'h77);
      rd(8'h0b, 1'b0, 8'hfb);
      rd(8'h0f, 1'b0, 8'hff);
      rd(8'h01, 1'b0, 8'h00);
      wr(8'hfd, 8'h20);
      rd(8'h03, 1'b0, 8'h33);
      rd(8'h0b, 1'b0, 8'hbb);
      wr(8'h24, 8'h5c);
      rd(8'h04, 1'b1, 8'h5c);
      $display("regs done %0d", err_total);
   endtask
   task automatic t_stack;
      wr(8'hfd, 8'h00);
      wr(8'hf8, 8'h04);
      wr(8'hfe, 8'h12);
      wr(8'hff, 8'h80);
      stk(0);
      rd(8'hff, 1'b0, 8'h7f);
      rd(8'hfe, 1'b0, 8'h12);
      stk(1);
      rd(8'hff, 1'b0, 8'h80);
      jmp(16'h0345);
      stk(2);
      rd(8'h7f, 1'b0, 8'h45);
      rd(8'h7e, 1'b0, 8'h03);
      jmp(16'h0800);
      stk(3);
      chk(pc, 16'h0345);
      wr(8'hfc, 8'h5a);
      stk(4);
      chk(pc, irq_vector);
      rd(8'hff, 1'b0, 8'h7d);
      wr(8'hfc, 8'h00);
      stk(5);
      chk(pc, 16'h0345);
      rd(8'hfc, 1'b0, 8'h5a);
      rd(8'hfe, 1'b0, 8'h12);
      $display("stack done %0d", err_total);
   endtask
   task automatic t_fetch;
      jmp(16'h0100);
      do_fetch;
      chk({8'h0, fetch_data}, 16'h003c);
      chk(pc, 16'h0101);
      jmp(ROM_TOP + 16'h1);
      do_fetch;
      chk({8'h0, fetch_data}, 16'h004a);
      chk(seen_addr, 16'h1000);
      $display("fetch done %0d", err_total);
   endtask
   task automatic t_load;
      wr(8'hf7, 8'h18);
      do_ld(1'b0, 1'b0, 16'h1234, 8'h00, 1);
      chk({8'h0, ld_rdata}, 16'h0046);
      chk({15'h0, seen_dm_n}, 16'h0000);
      do_ld(1'b1, 1'b0, 16'h2345, 8'h00, 1);
      chk({8'h0, ld_rdata}, 16'h003c);
      chk({15'h0, seen_dm_n}, 16'h0001);
      do_ld(1'b0, 1'b1, 16'h1300, 8'hc3, 1);
      do_ld(1'b0, 1'b0, 16'h1300, 8'h00, 1);
      chk({8'h0, ld_rdata}, 16'h00c3);
      @(posedge mclk);
      rom_protect_strap <= 1'b1;
      ld_incr <= 1'b1;
      do_ld(1'b1, 1'b0, 16'h2000, 8'h00, 2);
      chk(seen_addr, 16'h1300);
      $display("load done %0d", err_total);
   endtask
   initial
   begin
      {rst, rom_protect_strap, reg_wr, reg_rd, reg_working, fetch_req, jump} = 7'h40;
      {ld_prog, ld_ext, ld_incr, ld_write} = 4'h0;
      {stk_push, stk_pop, stk_call, stk_ret, stk_irq, stk_return_from_interrupt} = 6'h00;
      {reg_addr, reg_wdata, ld_wdata} = 24'h0;
      {jump_addr, ld_addr, irq_vector} = {16'h0, 16'h0, 16'h0200};
      err_total = 0;
      n_checks = 0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      t_regs;
      t_stack;
      t_fetch;
      t_load;
      close_out;
   end
endmodule // asp_addr_space_test
